// ### logic/sgc_pkg.sv
// Purpose: Constants and types for the switchgear command control block
// Assumes: One 10 MHz clock, asynchronous active-low reset
// Notes:   Times in microseconds, cycle counts derived from the clock rate
`default_nettype none
package sgc_pkg;
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned TRAVEL_US    = 100_000;
   localparam int unsigned HOLD_US      = 200_000;
   localparam int unsigned BYPASS_US    = 60_000_000;
   localparam int unsigned TRAVEL_CYC   = TRAVEL_US * (CLK_HZ / 1_000_000);
   localparam int unsigned HOLD_CYC     = HOLD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BYPASS_CYC   = BYPASS_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CMD_PULSE_CYC = 1000;
   localparam int unsigned CNT_W        = 32;
   localparam int unsigned NUM_SLOTS    = 8;
   localparam int unsigned NUM_IL       = 3;

   // APB register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_SLOTS    = 8'h04;
   localparam logic [7:0] REG_CMD      = 8'h08;
   localparam logic [7:0] REG_STATUS   = 8'h0C;
   localparam logic [7:0] REG_HOLD     = 8'h10;
   localparam logic [7:0] REG_TRAVEL   = 8'h14;
   localparam logic [7:0] REG_BYPASS   = 8'h18;

   // CTRL fields
   localparam int unsigned CTRL_AUTH_LSB   = 0;
   localparam int unsigned CTRL_BYP_LSB    = 2;
   localparam int unsigned CTRL_BYP_EN     = 4;
   localparam int unsigned CTRL_LATCH      = 5;
   localparam int unsigned CTRL_OVR_EN     = 6;
   localparam int unsigned CTRL_OVR_LSB    = 7;
   localparam int unsigned CTRL_CLOSE_WIRED = 9;
   localparam int unsigned CTRL_OPEN_WIRED  = 10;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0623;

   // CMD fields (write-one pulses)
   localparam int unsigned CMD_CLOSE = 0;
   localparam int unsigned CMD_OPEN  = 1;
   localparam int unsigned CMD_ACK   = 2;

   localparam logic [31:0] SLOTS_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      AUTH_NONE, AUTH_LOCAL, AUTH_REMOTE, AUTH_BOTH
   } sgc_auth_type;

   typedef enum logic [1:0] {
      BYP_SINGLE, BYP_PERMANENT, BYP_TIMED, BYP_OFF
   } sgc_bypass_type;

   localparam logic [1:0] POS_TRANSIT   = 2'h0;
   localparam logic [1:0] POS_OPEN      = 2'h1;
   localparam logic [1:0] POS_CLOSED    = 2'h2;
   localparam logic [1:0] POS_DISTURBED = 2'h3;
endpackage
`default_nettype wire

// ### logic/sgc_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs asynchronous to mclk_i
// Notes:   First stage is read only by the second
`default_nettype none
module sgc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sgc_sync_state_type;

   sgc_sync_state_type st;
   sgc_sync_state_type next_st;

   always_comb begin
      next_st.meta   = async_i;
      next_st.stable = st.meta;
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_o = st.stable;
endmodule
`default_nettype wire

// ### logic/sgc_timer.sv
// Purpose: Loadable down-counter with a running flag
// Assumes: Load value of zero means expire at once
// Notes:   Used for travel supervision, trip hold and bypass window
`default_nettype none
module sgc_timer #(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic             load_i,
   input  wire logic             stop_i,
   input  wire logic [WIDTH-1:0] value_i,
   output logic                  running_o
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             run;
   } sgc_timer_state_type;

   sgc_timer_state_type st;
   sgc_timer_state_type next_st;

   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.count = value_i;
         next_st.run   = (value_i != '0);
      end else if (stop_i) begin
         next_st.run = 1'b0;
      end else if (st.run) begin
         next_st.count = st.count - 1'b1;
         if (st.count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
            next_st.run = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign running_o = st.run;
endmodule
`default_nettype wire

// ### logic/sgc_top.sv
// Purpose: Command control and trip manager for one breaker
// Assumes: Pins and panel keys are asynchronous; APB on mclk_i
// Notes:   Summary of operation below
//
// Summary of operation
// - State code: transit0 open1 closed2 disturbed3
// - Travel timer runs per command, fault on expiry
// - Unwired open contact reports disturbed
// - Three interlocks per direction block that direction
// - Protection open and reclose ignore interlocks
// - Trip output ORs assigned trip slots
// - Unassigned trip sources never reach breaker
// - Trip held for minimum hold time
// - Latched trip held until acknowledged
// - Latch clears on ack after sources drop
// - External close and open requests accepted
// - Simultaneous open beats close
// - Close on rising edge, open on level
// - SCADA needs remote or both authority
// - Authority decode: none, local, remote, both
// - Authority never affects protection trips
// - Bypass modes: single, permanent, timed
// - Bypass time limit applies to single too
// - Bypass input signal enables bypass
// - Override replaces state and flags it
// - One command at a time, others ignored except protection open over a running close
// - No command toward position already held
// - One close pulse per panel key press
`default_nettype none
module sgc_top
   import sgc_pkg::*;
#(
   parameter int unsigned SLOTS = NUM_SLOTS,
   parameter logic [31:0] TRAVEL_DEF = 32'(TRAVEL_CYC),
   parameter logic [31:0] HOLD_DEF   = 32'(HOLD_CYC),
   parameter logic [31:0] BYPASS_DEF = 32'(BYPASS_CYC),
   parameter logic [31:0] PULSE_DEF  = 32'(CMD_PULSE_CYC)
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [7:0]       paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   input  wire logic             aux_closed_i,
   input  wire logic             aux_open_i,
   input  wire logic [SLOTS-1:0] prot_trip_i,
   input  wire logic             prot_open_block_i,
   input  wire logic             auto_reclose_i,
   input  wire logic [NUM_IL-1:0] close_interlock_i,
   input  wire logic [NUM_IL-1:0] open_interlock_i,
   input  wire logic             ext_close_request_i,
   input  wire logic             ext_open_request_i,
   input  wire logic             panel_close_key_i,
   input  wire logic             panel_open_key_i,
   input  wire logic             trip_ack_input_i,
   input  wire logic             bypass_duration_i,
   output logic                  close_cmd_o,
   output logic                  open_cmd_o,
   output logic                  trip_o,
   output logic      [1:0]       breaker_state_code_o,
   output logic                  transit_indication_o,
   output logic                  fault_indication_o,
   output logic                  override_flag_o
);
   localparam int unsigned NPIN = SLOTS + 2 * NUM_IL + 10;

   typedef struct packed {
      logic [31:0]      ctrl;
      logic [31:0]      slots;
      logic [31:0]      hold;
      logic [31:0]      travel;
      logic [31:0]      bypass;
      logic [31:0]      rdata;
      logic             ready;
      logic             err;
      logic             ext_close_d;
      logic             key_close_d;
      logic             latched;
      logic             trip;
      logic             closing;
      logic             opening;
      logic [31:0]      pulse;
      logic             fault;
      logic             byp_used;
      logic [1:0]       state;
      logic             close_q;
      logic             open_q;
      logic             busy_q;
   } sgc_state_type;

   sgc_state_type st;
   sgc_state_type next_st;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin;
   logic             trav_run;
   logic             hold_run;
   logic             byp_run;
   logic             trav_load;
   logic             hold_load;
   logic             byp_load;

   assign pin_raw = {prot_trip_i, close_interlock_i, open_interlock_i, aux_closed_i, aux_open_i,
                     prot_open_block_i, auto_reclose_i, ext_close_request_i, ext_open_request_i,
                     panel_close_key_i, panel_open_key_i, trip_ack_input_i, bypass_duration_i};

   sgc_sync #(.WIDTH(NPIN)) u_sync (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .async_i(pin_raw),
      .sync_o (pin)
   );

   logic [SLOTS-1:0]  s_trip;
   logic [NUM_IL-1:0] s_cil;
   logic [NUM_IL-1:0] s_oil;
   logic s_auxc, s_auxo, s_pblk, s_ar, s_exc, s_exo, s_kc, s_ko, s_ack, s_bypin;
   assign {s_trip, s_cil, s_oil, s_auxc, s_auxo, s_pblk, s_ar, s_exc, s_exo,
           s_kc, s_ko, s_ack, s_bypin} = pin;

   sgc_timer #(.WIDTH(32)) u_travel (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .load_i   (trav_load),
      .stop_i   (1'b0),
      .value_i  (st.travel),
      .running_o(trav_run)
   );

   sgc_timer #(.WIDTH(32)) u_hold (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .load_i   (hold_load),
      .stop_i   (1'b0),
      .value_i  (st.hold),
      .running_o(hold_run)
   );

   sgc_timer #(.WIDTH(32)) u_bypass (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .load_i   (byp_load),
      .stop_i   (1'b0),
      .value_i  (st.bypass),
      .running_o(byp_run)
   );

   // Combinational decode
   logic         wr;
   logic         rd_sel;
   logic         ack_evt;
   logic         sw_close;
   logic         sw_open;
   sgc_auth_type auth;
   sgc_bypass_type bmode;
   logic         local_ok;
   logic         remote_ok;
   logic         bypass_on;
   logic         busy;
   logic [SLOTS-1:0] assigned;
   logic         any_src;
   logic         close_req;
   logic         open_req;
   logic         ar_close;
   logic         prot_open;
   logic [1:0]   raw_state;
   logic [1:0]   vstate;

   always_comb begin
      wr        = psel_i && penable_i && pwrite_i;
      rd_sel    = psel_i && !penable_i && !pwrite_i;
      auth      = sgc_auth_type'(st.ctrl[CTRL_AUTH_LSB +: 2]);
      bmode     = sgc_bypass_type'(st.ctrl[CTRL_BYP_LSB +: 2]);
      sw_close  = wr && (paddr_i == REG_CMD) && pwdata_i[CMD_CLOSE];
      sw_open   = wr && (paddr_i == REG_CMD) && pwdata_i[CMD_OPEN];
      ack_evt   = (wr && (paddr_i == REG_CMD) && pwdata_i[CMD_ACK]) || s_ack;
      local_ok  = (auth == AUTH_LOCAL) || (auth == AUTH_BOTH);
      remote_ok = (auth == AUTH_REMOTE) || (auth == AUTH_BOTH);
      // Bypass window shared by timed and single modes
      bypass_on = s_bypin
               || (st.ctrl[CTRL_BYP_EN] && bmode == BYP_PERMANENT)
               || (byp_run && bmode == BYP_TIMED)
               || (byp_run && bmode == BYP_SINGLE && !st.byp_used);
      busy      = st.closing || st.opening;
      assigned  = st.slots[SLOTS-1:0];
      any_src   = |(s_trip & assigned);
      // Request gathering; close only on edges
      close_req = (remote_ok && (sw_close || (s_exc && !st.ext_close_d)))
               || (local_ok && s_kc && !st.key_close_d);
      open_req  = (remote_ok && (sw_open || s_exo)) || (local_ok && s_ko);
      ar_close  = s_ar;
      prot_open = st.trip && !s_pblk;
      // Position decode
      if (!st.ctrl[CTRL_OPEN_WIRED] && !st.ctrl[CTRL_CLOSE_WIRED]) begin
         raw_state = POS_DISTURBED;
      end else if (!st.ctrl[CTRL_OPEN_WIRED]) begin
         raw_state = POS_DISTURBED;
      end else if (!st.ctrl[CTRL_CLOSE_WIRED]) begin
         raw_state = s_auxo ? POS_OPEN : POS_CLOSED;
      end else if (s_auxc && !s_auxo) begin
         raw_state = POS_CLOSED;
      end else if (!s_auxc && s_auxo) begin
         raw_state = POS_OPEN;
      end else begin
         raw_state = (st.fault || (!trav_run && busy)) ? POS_DISTURBED : POS_TRANSIT;
      end
      vstate = st.ctrl[CTRL_OVR_EN] ? st.ctrl[CTRL_OVR_LSB +: 2] : raw_state;
   end

   always_comb begin
      next_st   = st;
      trav_load = 1'b0;
      hold_load = 1'b0;
      byp_load  = 1'b0;
      next_st.ext_close_d = s_exc;
      next_st.key_close_d = s_kc;
      next_st.state = vstate;
      // APB slave, zero wait states
      next_st.ready = psel_i && !penable_i;
      next_st.err   = 1'b0;
      if (rd_sel) begin
         case (paddr_i)
            REG_CTRL:   next_st.rdata = st.ctrl;
            REG_SLOTS:  next_st.rdata = st.slots;
            REG_HOLD:   next_st.rdata = st.hold;
            REG_TRAVEL: next_st.rdata = st.travel;
            REG_BYPASS: next_st.rdata = st.bypass;
            REG_STATUS: next_st.rdata = {24'h00_0000, busy, st.latched, byp_run,
                                         st.fault, trav_run, st.trip, vstate};
            REG_CMD:    next_st.rdata = 32'h0000_0000;
            default:    next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (psel_i && !penable_i) begin
         case (paddr_i)
            REG_CTRL, REG_SLOTS, REG_CMD, REG_STATUS, REG_HOLD, REG_TRAVEL, REG_BYPASS:
               next_st.err = 1'b0;
            default: next_st.err = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr_i)
            REG_CTRL: begin
               next_st.ctrl = pwdata_i;
               if (pwdata_i[CTRL_BYP_EN] && !st.ctrl[CTRL_BYP_EN]) begin
                  byp_load         = 1'b1;
                  next_st.byp_used = 1'b0;
               end
            end
            REG_SLOTS:  next_st.slots  = pwdata_i;
            REG_HOLD:   next_st.hold   = pwdata_i;
            REG_TRAVEL: next_st.travel = pwdata_i;
            REG_BYPASS: next_st.bypass = pwdata_i;
            default:    next_st.ctrl   = st.ctrl;
         endcase
      end
      // Trip manager
      if (any_src && !st.trip) begin
         next_st.trip = 1'b1;
         hold_load    = 1'b1;
      end
      if (any_src && st.ctrl[CTRL_LATCH]) begin
         next_st.latched = 1'b1;
      end else if (st.latched && !any_src
                   && (ack_evt || !st.ctrl[CTRL_LATCH] || assigned == '0)) begin
         next_st.latched = 1'b0;
      end
      if (st.trip && !any_src && !hold_run && !hold_load && !st.latched) begin
         next_st.trip = 1'b0;
      end
      // Command sequencer
      if (busy) begin
         if ((st.closing && vstate == POS_CLOSED) || (st.opening && vstate == POS_OPEN)) begin
            next_st.closing = 1'b0;
            next_st.opening = 1'b0;
         end else if (!trav_run) begin
            next_st.fault   = 1'b1;
            next_st.closing = 1'b0;
            next_st.opening = 1'b0;
         end
         // Protection open preempts a running close
         if (prot_open && st.closing && vstate != POS_OPEN) begin
            next_st.closing = 1'b0;
            next_st.opening = 1'b1;
            trav_load       = 1'b1;
            next_st.fault   = 1'b0;
         end
      end else if (prot_open && vstate != POS_OPEN) begin
         next_st.opening = 1'b1;
         trav_load       = 1'b1;
         next_st.fault   = 1'b0;
      end else if (open_req && vstate != POS_OPEN
                   && ((s_oil == '0) || bypass_on)) begin
         next_st.opening = 1'b1;
         trav_load       = 1'b1;
         next_st.fault   = 1'b0;
         next_st.byp_used = next_st.byp_used | (s_oil != '0);
      end else if ((close_req || ar_close) && !open_req && vstate != POS_CLOSED
                   && (ar_close || (s_cil == '0) || bypass_on)) begin
         next_st.closing = 1'b1;
         trav_load       = 1'b1;
         next_st.fault   = 1'b0;
         next_st.byp_used = next_st.byp_used | (!ar_close && s_cil != '0);
      end
      if (trav_load) begin
         next_st.pulse = PULSE_DEF;
      end else if (st.pulse != 32'h0000_0000) begin
         next_st.pulse = st.pulse - 32'h0000_0001;
      end
      // Outputs come from flops so the breaker coil never sees a decode glitch
      next_st.close_q = next_st.closing && (next_st.pulse != 32'h0000_0000);
      next_st.open_q  = next_st.opening && (next_st.pulse != 32'h0000_0000);
      next_st.busy_q  = next_st.closing || next_st.opening;
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st        <= '0;
         st.ctrl   <= CTRL_RESET;
         st.slots  <= SLOTS_RESET;
         st.hold   <= HOLD_DEF;
         st.travel <= TRAVEL_DEF;
         st.bypass <= BYPASS_DEF;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o             = st.rdata;
   assign pready_o             = st.ready;
   assign pslverr_o            = st.err;
   assign close_cmd_o          = st.close_q;
   assign open_cmd_o           = st.open_q;
   assign trip_o               = st.trip;
   assign breaker_state_code_o = st.state;
   assign transit_indication_o = st.busy_q;
   assign fault_indication_o   = st.fault;
   assign override_flag_o      = st.ctrl[CTRL_OVR_EN];
endmodule
`default_nettype wire

// ### test/sgc_breaker_model.sv
// Purpose: Breaker with two position contacts, far side of the bench
// Assumes: Moves on a command level, travel takes DLY cycles
// Notes:   stall_i jams it mid-travel with both contacts open
`default_nettype none
module sgc_breaker_model #(
   parameter int DLY = 10
) (
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic close_i,
   input  wire logic open_i,
   input  wire logic stall_i,
   output logic      aux_closed_o,
   output logic      aux_open_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cnt;
   logic tgt;

   // The made contact drops at once on a move, leaving both open, so the block sees a real transit
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt          <= 0;
         tgt          <= 1'h0;
         aux_closed_o <= 1'h0;
         aux_open_o   <= 1'h1;
      end else if (open_i && aux_closed_o) begin
         cnt          <= DLY;
         tgt          <= 1'h0;
         aux_closed_o <= 1'h0;
      end else if (close_i && aux_open_o) begin
         cnt        <= DLY;
         tgt        <= 1'h1;
         aux_open_o <= 1'h0;
      end else if (cnt != 0 && !stall_i) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            aux_closed_o <= tgt;
            aux_open_o   <= !tgt;
         end
      end
   end
endmodule
`default_nettype wire

// ### test/sgc_top_monitor.sv
// Purpose: Port checker for the switchgear command control block
// Assumes: Sees only top ports; hold and pulse figures from its parameters
// Notes:   Pulse length allows one cycle of register slack
`default_nettype none
module sgc_top_monitor
   import sgc_pkg::*;
#(
   parameter int unsigned SLOTS     = NUM_SLOTS,
   parameter logic [31:0] HOLD_DEF  = 32'h14,
   parameter logic [31:0] PULSE_DEF = 32'h5
) (
   input wire logic             mclk_i,
   input wire logic             nrst_i,
   input wire logic             psel_i,
   input wire logic             penable_i,
   input wire logic [7:0]       paddr_i,
   input wire logic             pready_o,
   input wire logic             pslverr_o,
   input wire logic [SLOTS-1:0] prot_trip_i,
   input wire logic             close_cmd_o,
   input wire logic             trip_o,
   input wire logic [1:0]       breaker_state_code_o,
   input wire logic             transit_indication_o
);
   logic [31:0] trip_len;
   logic [31:0] close_len;
   logic [3:0]  idle_src;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // Run lengths, and cycles since a trip source was last seen (saturates)
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trip_len  <= 32'h0;
         close_len <= 32'h0;
         idle_src  <= 4'hF;
      end else begin
         trip_len  <= trip_o ? trip_len + 32'h1 : 32'h0;
         close_len <= close_cmd_o ? close_len + 32'h1 : 32'h0;
         idle_src  <= (|prot_trip_i) ? 4'h0 : ((idle_src == 4'hF) ? 4'hF : idle_src + 4'h1);
      end
   end

   setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   ready_once_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   unmapped_err_a: assert property (pready_o && paddr_i > 8'h18 |-> pslverr_o)
      else $error("unmapped access without error");
   hold_min_a: assert property ($fell(trip_o) |-> trip_len >= HOLD_DEF - 32'h1)
      else $error("trip dropped before hold time");
   trip_cause_a: assert property ($rose(trip_o) |-> idle_src < 4'h8)
      else $error("trip without a source");
   pulse_len_a: assert property ($fell(close_cmd_o) |-> close_len >= PULSE_DEF && close_len <= PULSE_DEF + 32'h1)
      else $error("close pulse length wrong");
   no_redundant_a: assert property ($rose(close_cmd_o) |-> $past(breaker_state_code_o) != POS_CLOSED)
      else $error("close toward closed breaker");
   one_at_time_a: assert property ($rose(close_cmd_o) |-> !$past(transit_indication_o))
      else $error("close while command running");
   transit_shown_a: assert property ($rose(close_cmd_o) |-> ##[0:2] transit_indication_o)
      else $error("no transit after close");
endmodule

bind sgc_top sgc_top_monitor #(.SLOTS(SLOTS), .HOLD_DEF(HOLD_DEF), .PULSE_DEF(PULSE_DEF)) sgc_top_monitor_i (
   .mclk_i, .nrst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .prot_trip_i,
   .close_cmd_o, .trip_o, .breaker_state_code_o, .transit_indication_o);
`default_nettype wire

// ### test/sgc_top_tb.sv
// Purpose: Self-checking bench for the switchgear command control block
// Assumes: Short timing parameters, breaker model on the far side
// Notes:   One sequence; every wait is bounded
`default_nettype none
module sgc_top_tb
   import sgc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_i = 1'h0;
   logic        nrst_i = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00, prot = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  cil = 3'h0, oil = 3'h0;
   logic        xc = 1'h0, xo = 1'h0, pkc = 1'h0, pko = 1'h0, ack = 1'h0, byp = 1'h0, stall = 1'h0;
   logic        auxc, auxo, ccmd, ocmd, trip, trans, flt, ovr, pc = 1'h0, po = 1'h0, pblk = 1'h0, ar = 1'h0;
   logic [1:0]  st;
   int          n_mismatch = 0, samples_checked = 0, seed = 8, n_close = 0, n_open = 0, k, j;

   always #50 mclk_i = ~mclk_i;

   sgc_top #(.TRAVEL_DEF(32'h32), .HOLD_DEF(32'h14), .BYPASS_DEF(32'h64), .PULSE_DEF(32'h5)) sgc_top_i (
      .mclk_i, .nrst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .aux_closed_i(auxc),
      .aux_open_i(auxo), .prot_trip_i(prot), .prot_open_block_i(pblk), .auto_reclose_i(ar),
      .close_interlock_i(cil), .open_interlock_i(oil), .ext_close_request_i(xc), .ext_open_request_i(xo),
      .panel_close_key_i(pkc), .panel_open_key_i(pko), .trip_ack_input_i(ack), .bypass_duration_i(byp),
      .close_cmd_o(ccmd), .open_cmd_o(ocmd), .trip_o(trip), .breaker_state_code_o(st),
      .transit_indication_o(trans), .fault_indication_o(flt), .override_flag_o(ovr));
   sgc_breaker_model sgc_breaker_model_i (.mclk_i, .nrst_i, .close_i(ccmd), .open_i(ocmd | trip),
      .stall_i(stall), .aux_closed_o(auxc), .aux_open_o(auxo));

   // Command pulses counted by rising edge, so a stretched pulse still counts once
   always @(posedge mclk_i) begin
      pc <= ccmd;
      po <= ocmd;
      if (ccmd === 1'h1 && pc !== 1'h1) n_close = n_close + 1;
      if (ocmd === 1'h1 && po !== 1'h1) n_open = n_open + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'h1;
      i = 0;
      do begin
         @(posedge mclk_i);
         i++;
      end while (pready !== 1'h1 && i < 20);
      if (i >= 20) begin
         $display("[ERR] %0t bus wait timed out", $time);
         n_mismatch++;
         close_out;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wait_st(input logic [1:0] e);
      int i;
      for (i = 0; i < 300 && st !== e; i++) @(posedge mclk_i);
      chk(32'(st), 32'(e));
   endtask

   initial begin
      cyc(12);
      nrst_i <= 1'h1;
      apb(1'h1, 8'h20, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'h0, REG_CTRL, 32'h0);
      chk(rd, CTRL_RESET);
      wait_st(POS_OPEN);
      k = n_open;
      apb(1'h1, REG_CMD, 32'h2);
      cyc(20);
      chk(n_open, k);
      // Interlocked key press is dropped; the bypass input lets the next through
      cil[$unsigned($random(seed)) % 3] <= 1'h1;
      k = n_close;
      pkc <= 1'h1;
      cyc(30);
      pkc <= 1'h0;
      cyc(30);
      chk(n_close, k);
      byp <= 1'h1;
      pkc <= 1'h1;
      cyc(60);
      pkc <= 1'h0;
      byp <= 1'h0;
      cil <= 3'h0;
      chk(n_close, k + 1);
      wait_st(POS_CLOSED);
      apb(1'h1, REG_CTRL, 32'h622);
      k = n_open;
      pko <= 1'h1;
      cyc(20);
      pko <= 1'h0;
      chk(n_open, k);
      k = n_close;
      xo <= 1'h1;
      xc <= 1'h1;
      wait_st(POS_OPEN);
      xo <= 1'h0;
      cyc(20);
      chk(n_close, k);
      xc <= 1'h0;
      cyc(2);
      xc <= 1'h1;
      wait_st(POS_CLOSED);
      xc <= 1'h0;
      // An open interlock holds the level request back
      k = n_open;
      oil[$unsigned($random(seed)) % 3] <= 1'h1;
      xo <= 1'h1;
      cyc(20);
      chk(n_open, k);
      xo <= 1'h0;
      oil <= 3'h0;
      stall <= 1'h1;
      apb(1'h1, REG_CMD, 32'h2);
      cyc(4);
      chk(32'(trans), 32'h1);
      cyc(70);
      chk(32'(flt), 32'h1);
      chk(32'(st), 32'(POS_DISTURBED));
      stall <= 1'h0;
      wait_st(POS_OPEN);
      apb(1'h1, REG_CTRL, 32'h222);
      wait_st(POS_DISTURBED);
      apb(1'h1, REG_CTRL, 32'h762);
      wait_st(POS_CLOSED);
      chk(32'(ovr), 32'h1);
      // No authority and latching on: trips must still pass
      apb(1'h1, REG_CTRL, 32'h620);
      k = $unsigned($random(seed)) % 8;
      j = (k + 1 + $unsigned($random(seed)) % 7) % 8;
      apb(1'h1, REG_SLOTS, 32'h1 << k);
      prot[j] <= 1'h1;
      cyc(30);
      chk(32'(trip), 32'h0);
      prot[j] <= 1'h0;
      prot[k] <= 1'h1;
      cyc(5);
      prot[k] <= 1'h0;
      cyc(5);
      chk(32'(trip), 32'h1);
      cyc(40);
      chk(32'(trip), 32'h1);
      prot[k] <= 1'h1;
      ack <= 1'h1;
      cyc(10);
      ack <= 1'h0;
      chk(32'(trip), 32'h1);
      prot[k] <= 1'h0;
      cyc(10);
      chk(32'(trip), 32'h1);
      ack <= 1'h1;
      cyc(5);
      ack <= 1'h0;
      cyc(3);
      chk(32'(trip), 32'h0);
      apb(1'h1, REG_CTRL, 32'h600);
      prot[k] <= 1'h1;
      cyc(2);
      prot[k] <= 1'h0;
      cyc(15);
      chk(32'(trip), 32'h1);
      cyc(15);
      chk(32'(trip), 32'h0);
      // Reclose ignores interlocks; a blocked protection open sends no open pulse
      cil[$unsigned($random(seed)) % 3] <= 1'h1;
      ar <= 1'h1;
      wait_st(POS_CLOSED);
      ar <= 1'h0;
      cil <= 3'h0;
      j = n_open;
      pblk <= 1'h1;
      prot[k] <= 1'h1;
      cyc(10);
      chk(32'(trip), 32'h1);
      chk(n_open, j);
      close_out;
   end
endmodule
`default_nettype wire
